// >>> rtl/usb_frame_addr_pkg.sv
// constants for the endpoint, frame and address block of the serial engine
package usb_frame_addr_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [14:0] IDX_ENDPOINT_CONTROL    = 15'h7F80;
  localparam logic [14:0] IDX_FRAME_LO   = 15'h7F90;
  localparam logic [14:0] IDX_FRAME_HI   = 15'h7F91;
  localparam logic [14:0] IDX_LOCAL_ADDR = 15'h7F92;
  localparam logic [14:0] IDX_SECOND_ADR = 15'h7F99;
  localparam logic [14:0] IDX_ENGINE_CFG = 15'h7FA0;

  localparam int          ADDR_W         = 17;
  localparam logic [16:0] ADDR_ENDPOINT_CONTROL    = {IDX_ENDPOINT_CONTROL, 2'b00};
  localparam logic [16:0] ADDR_EP_LAST    = {IDX_ENDPOINT_CONTROL + 15'h000F, 2'b00};
  localparam logic [16:0] ADDR_FRAME_LO   = {IDX_FRAME_LO, 2'b00};
  localparam logic [16:0] ADDR_FRAME_HI   = {IDX_FRAME_HI, 2'b00};
  localparam logic [16:0] ADDR_LOCAL_ADDR = {IDX_LOCAL_ADDR, 2'b00};
  localparam logic [16:0] ADDR_SECOND_ADR = {IDX_SECOND_ADR, 2'b00};
  localparam logic [16:0] ADDR_ENGINE_CFG = {IDX_ENGINE_CFG, 2'b00};

  // endpoint_control fields
  localparam int BIT_TX_ISO    = 7;
  localparam int BIT_RX_ISO    = 6;
  localparam int BIT_IN_HI     = 5;
  localparam int BIT_OUT_HI    = 4;
  localparam int BIT_IN_LO     = 3;
  localparam int BIT_OUT_LO    = 2;
  localparam int BIT_TX_PARITY = 1;
  localparam int BIT_RX_PARITY = 0;

  // address registers and engine_config fields
  localparam int BIT_PROMISC   = 7;
  localparam int BIT_SECOND_EN = 7;
  localparam int BIT_EXT_EN    = 0;
  localparam logic [3:0] LOCAL_EP_MAX = 4'h3;

  // reset values
  localparam logic [7:0] RST_ENDPOINT_CONTROL = 8'h00;
  localparam logic [7:0] RST_REG     = 8'h00;

  // frame timing, in usb bit clock periods
  localparam int          CNT_W     = 15;
  localparam logic [14:0] FRAME_TOL = 15'h0003;

  // response control codes
  localparam logic [1:0] RC_DISABLED = 2'b00;
  localparam logic [1:0] RC_STALL    = 2'b01;
  localparam logic [1:0] RC_NORMAL   = 2'b10;
  localparam logic [1:0] RC_NAK      = 2'b11;

  // handshake that the engine is told to send
  typedef enum logic [1:0] {
    HS_NONE  = 2'b00,
    HS_STALL = 2'b01,
    HS_ACK   = 2'b10,
    HS_NAK   = 2'b11
  } handshake_e;

  // transaction tracking, gray along idle -> busy -> idle
  typedef enum logic [0:0] {
    TXN_IDLE = 1'b0,
    TXN_BUSY = 1'b1
  } txn_e;

endpackage

// >>> rtl/usb_frame_addr.sv
// endpoint control, frame number and function address logic of the serial engine
// Functional notes
// - non-iso transmit success flips transmit parity
// - isochronous transmit leaves transmit parity alone
// - bit 0 shows last received data parity
// - iso receive records parity, no mismatch error
// - sixteen endpoint registers, token endpoint selects
// - writes to the endpoint of the current transaction take effect after it
// - last write during transaction is applied
// - good sof loads 11-bit frame number
// - bad sof increments frame number instead of loading it
// - missing or erroneous sof increments frame
// - sof missing outside plus/minus three clocks; only lateness past plus three is checked, an early sof is taken as good
// - expected length is last sof interval
// - extended bits load only when enabled
// - promiscuous mode skips address compare
// - promiscuous mode ignores token crc errors
// - local address serves endpoints zero to three
// - enabled second address serves all sixteen
// - disabled second address never matches
// - second address low seven bits compared
// - response codes disabled stall normal nak
// - transaction end rising edge qualifies loads
`timescale 1ns/10ps
module usb_frame_addr (
  input  wire logic                               core_clk,
  input  wire logic                               rst,
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [usb_frame_addr_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                        pwdata,
  output logic      [31:0]                        prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  input  wire logic                               bitTick,
  input  wire logic                               tokenValid,
  input  wire logic [6:0]                         tokenAddr,
  input  wire logic [3:0]                         tokenEndp,
  input  wire logic                               tokenCrcOk,
  input  wire logic                               transactionEnd,
  input  wire logic                               ackStatus,
  input  wire logic                               startOfFrameSeen,
  input  wire logic [15:0]                        sofFrame,
  input  wire logic                               txSuccess,
  input  wire logic                               rxPidValid,
  input  wire logic                               rxPid,
  input  wire logic                               rxReady,
  input  wire logic                               txQueued,
  output logic                                    endpointMatch,
  output logic                                    alternateHit,
  output logic      [3:0]                         activeEndpoint,
  output logic      [7:0]                         activeControl,
  output usb_frame_addr_pkg::handshake_e          inHandshake,
  output usb_frame_addr_pkg::handshake_e          outHandshake,
  output logic                                    acceptAll,
  output logic                                    rxToggleError
);
  import usb_frame_addr_pkg::*;

  typedef struct packed {
    logic [15:0][7:0] ctrl;
    logic [15:0][7:0] pend;
    logic [15:0]      pendFlag;
    logic [7:0]       frameLow;
    logic [7:0]       frameHigh;
    logic [7:0]       localAddr;
    logic [7:0]       secondAddr;
    logic [7:0]       engineCfg;
    txn_e             txn;
    logic [3:0]       curEp;
    logic             tePrev;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] expLen;
    logic             expValid;
    logic             match;
    logic             altHit;
    logic             rxErr;
    logic [31:0]      rdata;
  } blk_s;

  blk_s st_ff;
  blk_s nxt_st;

  logic       teRise;
  logic       setupPh;
  logic       accessPh;
  logic       epHit;
  logic       mapped;
  logic [3:0] regEp;
  logic [7:0] curCtrl;
  logic       localHit;
  logic       secondHit;
  logic       sofMissing;
  logic       extOn;
  logic [15:0] frameNow;
  logic [15:0] frameInc;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // rising edge of the engine's end-of-transaction level
  assign teRise   = transactionEnd & ~st_ff.tePrev;
  assign setupPh  = psel & ~penable;
  assign accessPh = psel & penable;
  assign epHit    = (paddr >= ADDR_ENDPOINT_CONTROL) && (paddr <= ADDR_EP_LAST) && (paddr[1:0] == 2'b00);
  assign regEp    = paddr[5:2];
  assign mapped   = epHit || (paddr == ADDR_FRAME_LO) || (paddr == ADDR_FRAME_HI)
                    || (paddr == ADDR_LOCAL_ADDR) || (paddr == ADDR_SECOND_ADR)
                    || (paddr == ADDR_ENGINE_CFG);
  assign curCtrl  = st_ff.ctrl[st_ff.curEp];
  assign extOn    = st_ff.engineCfg[BIT_EXT_EN];

  // address compare; local address only reaches the low four endpoints
  assign localHit  = (tokenAddr == st_ff.localAddr[6:0]) && (tokenEndp <= LOCAL_EP_MAX);
  assign secondHit = st_ff.secondAddr[BIT_SECOND_EN]
                     && (tokenAddr == st_ff.secondAddr[6:0]);

  // sof overdue beyond the tolerance window of the last interval
  // compared one bit wider so a saturated interval plus tolerance cannot wrap
  assign sofMissing = st_ff.expValid
                      && ({1'b0, st_ff.cnt} > ({1'b0, st_ff.expLen} + {1'b0, FRAME_TOL}));

  // frame count as one value; extended bits only take part when enabled
  assign frameNow = {st_ff.frameHigh, st_ff.frameLow};
  assign frameInc = extOn ? (frameNow + 16'h0001)
                          : {frameNow[15:11], (frameNow[10:0] + 11'h001)};

  ////////////////////////////////////////////////////////////////////////////
  // next state

  // one process for all state; later assignments take priority
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.tePrev = transactionEnd;
    nxt_st.rxErr  = 1'b0;

    // token decode picks the endpoint register for this transaction
    if (tokenValid) begin
      nxt_st.curEp  = tokenEndp;
      nxt_st.txn    = TXN_BUSY;
      nxt_st.altHit = ~localHit & secondHit;
      if (st_ff.localAddr[BIT_PROMISC]) begin
        nxt_st.match = 1'b1;
      end else begin
        nxt_st.match = tokenCrcOk & (localHit | secondHit);
      end
    end

    // transmit parity flips on acknowledged sends, never for isochronous
    if (txSuccess && !curCtrl[BIT_TX_ISO]) begin
      nxt_st.ctrl[st_ff.curEp][BIT_TX_PARITY] = ~curCtrl[BIT_TX_PARITY];
    end

    // received parity always recorded; repeat flagged only when not iso
    if (rxPidValid) begin
      nxt_st.ctrl[st_ff.curEp][BIT_RX_PARITY] = rxPid;
      nxt_st.rxErr = ~curCtrl[BIT_RX_ISO] & (rxPid == curCtrl[BIT_RX_PARITY]);
    end

    // frame interval counter, saturates so a dead bus cannot wrap it
    if (bitTick && (st_ff.cnt != {CNT_W{1'b1}})) begin
      nxt_st.cnt = st_ff.cnt + 15'h0001;
    end

    if (sofMissing) begin
      // fill in the lost sof and start a fresh interval
      nxt_st.frameLow  = frameInc[7:0];
      nxt_st.frameHigh = frameInc[15:8];
      nxt_st.cnt       = '0;
    end

    // status-qualified loads at the end of each transaction
    if (teRise) begin
      nxt_st.txn = TXN_IDLE;
      if (startOfFrameSeen) begin
        nxt_st.cnt      = '0;
        nxt_st.expLen   = st_ff.cnt;
        nxt_st.expValid = 1'b1;
        if (ackStatus) begin
          nxt_st.frameLow       = sofFrame[7:0];
          nxt_st.frameHigh[2:0] = sofFrame[10:8];
          if (extOn) begin
            nxt_st.frameHigh[7:3] = sofFrame[15:11];
          end
        end else begin
          // garbled number is never loaded, the count moves on instead
          nxt_st.frameLow  = frameInc[7:0];
          nxt_st.frameHigh = frameInc[15:8];
        end
      end
      // deferred endpoint writes land now, receive parity kept
      for (int i = 0; i < 16; i++) begin
        if (st_ff.pendFlag[i]) begin
          nxt_st.ctrl[i][7:1] = st_ff.pend[i][7:1];
          nxt_st.pendFlag[i]  = 1'b0;
        end
      end
    end

    // apb read data latched in the setup cycle
    if (setupPh) begin
      nxt_st.rdata = 32'h0000_0000;
      if (epHit) begin
        nxt_st.rdata[7:0] = st_ff.ctrl[regEp];
      end else if (paddr == ADDR_FRAME_LO) begin
        nxt_st.rdata[7:0] = st_ff.frameLow;
      end else if (paddr == ADDR_FRAME_HI) begin
        nxt_st.rdata[7:0] = st_ff.frameHigh;
      end else if (paddr == ADDR_LOCAL_ADDR) begin
        nxt_st.rdata[7:0] = st_ff.localAddr;
      end else if (paddr == ADDR_SECOND_ADR) begin
        nxt_st.rdata[7:0] = st_ff.secondAddr;
      end else if (paddr == ADDR_ENGINE_CFG) begin
        nxt_st.rdata[7:0] = {7'h00, st_ff.engineCfg[BIT_EXT_EN]};
      end
    end

    // apb writes; an endpoint busy in a transaction takes the value later
    if (accessPh && pwrite) begin
      if (epHit) begin
        if ((st_ff.txn == TXN_BUSY) && (regEp == st_ff.curEp) && !teRise) begin
          nxt_st.pend[regEp]     = pwdata[7:0];
          nxt_st.pendFlag[regEp] = 1'b1;
        end else begin
          nxt_st.ctrl[regEp][7:1] = pwdata[7:1];
        end
      end else if (paddr == ADDR_LOCAL_ADDR) begin
        nxt_st.localAddr = pwdata[7:0];
      end else if (paddr == ADDR_SECOND_ADR) begin
        nxt_st.secondAddr = pwdata[7:0];
      end else if (paddr == ADDR_ENGINE_CFG) begin
        nxt_st.engineCfg = {7'h00, pwdata[BIT_EXT_EN]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff            <= '0;
      st_ff.ctrl       <= {16{RST_ENDPOINT_CONTROL}};
      st_ff.frameLow   <= RST_REG;
      st_ff.frameHigh  <= RST_REG;
      st_ff.localAddr  <= RST_REG;
      st_ff.secondAddr <= RST_REG;
      st_ff.engineCfg  <= RST_REG;
      st_ff.txn        <= TXN_IDLE;
      // idle level of transaction end is high; avoids a false rise after reset
      st_ff.tePrev     <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // zero-wait slave; unmapped addresses answer with an error
  assign pready  = accessPh;
  assign pslverr = accessPh & ~mapped;
  assign prdata  = st_ff.rdata;

  assign endpointMatch  = st_ff.match;
  assign alternateHit   = st_ff.altHit;
  assign activeEndpoint = st_ff.curEp;
  assign activeControl  = curCtrl;
  assign acceptAll      = st_ff.localAddr[BIT_PROMISC];
  assign rxToggleError  = st_ff.rxErr;

  // handshake selection; isochronous receive never handshakes
  always_comb begin
    unique case ({curCtrl[BIT_OUT_HI], curCtrl[BIT_OUT_LO]})
      RC_DISABLED: outHandshake = HS_NONE;
      RC_STALL:    outHandshake = HS_STALL;
      RC_NORMAL:   outHandshake = rxReady ? HS_ACK : HS_NAK;
      RC_NAK:      outHandshake = HS_NAK;
    endcase
    if (curCtrl[BIT_RX_ISO]) begin
      outHandshake = HS_NONE;
    end
    unique case ({curCtrl[BIT_IN_HI], curCtrl[BIT_IN_LO]})
      RC_DISABLED: inHandshake = HS_NONE;
      RC_STALL:    inHandshake = HS_STALL;
      RC_NORMAL:   inHandshake = txQueued ? HS_ACK : HS_NAK;
      RC_NAK:      inHandshake = HS_NAK;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  chk_tx_parity_flip: assert property (@(posedge core_clk) disable iff (rst)
    txSuccess && !curCtrl[BIT_TX_ISO] && !teRise && !(accessPh && pwrite)
    |=> curCtrl[BIT_TX_PARITY] != $past(curCtrl[BIT_TX_PARITY]))
    else $error("transmit parity did not flip");

  chk_iso_parity_hold: assert property (@(posedge core_clk) disable iff (rst)
    txSuccess && curCtrl[BIT_TX_ISO] && !teRise && !(accessPh && pwrite) && !tokenValid
    |=> $stable(curCtrl[BIT_TX_PARITY]))
    else $error("isochronous transmit changed parity");

  chk_rx_parity_rec: assert property (@(posedge core_clk) disable iff (rst)
    rxPidValid && !tokenValid |=> curCtrl[BIT_RX_PARITY] == $past(rxPid))
    else $error("receive parity not recorded");

  chk_iso_no_error: assert property (@(posedge core_clk) disable iff (rst)
    rxPidValid && curCtrl[BIT_RX_ISO] |=> !rxToggleError)
    else $error("toggle error on isochronous endpoint");

  chk_defer_write: assert property (@(posedge core_clk) disable iff (rst)
    accessPh && pwrite && epHit && st_ff.txn == TXN_BUSY && regEp == st_ff.curEp && !teRise && !tokenValid
    |=> st_ff.pendFlag[st_ff.curEp] && $stable(curCtrl[7:2]))
    else $error("busy endpoint write applied early");

  chk_frame_load: assert property (@(posedge core_clk) disable iff (rst)
    teRise && startOfFrameSeen && ackStatus
    |=> st_ff.frameLow == $past(sofFrame[7:0]) && st_ff.frameHigh[2:0] == $past(sofFrame[10:8]))
    else $error("frame number not loaded");

  chk_ext_gated: assert property (@(posedge core_clk) disable iff (rst)
    teRise && startOfFrameSeen && ackStatus && !extOn |=> $stable(st_ff.frameHigh[7:3]))
    else $error("extended frame bits loaded while disabled");

  chk_promisc_match: assert property (@(posedge core_clk) disable iff (rst)
    tokenValid && acceptAll |=> endpointMatch)
    else $error("promiscuous token not accepted");

  chk_local_range: assert property (@(posedge core_clk) disable iff (rst)
    tokenValid && !acceptAll && !st_ff.secondAddr[BIT_SECOND_EN] && tokenEndp > LOCAL_EP_MAX
    |=> !endpointMatch)
    else $error("local address matched a high endpoint");

  chk_missing_fill: assert property (@(posedge core_clk) disable iff (rst)
    sofMissing && !teRise && !extOn |=> st_ff.frameLow == $past(frameInc[7:0]) && st_ff.cnt == 15'h0000)
    else $error("missing sof not filled in");

endmodule

// >>> dv/usb_host_model.sv
// host side model: tokens, data events and sof packets toward the block
`timescale 1ns/10ps
module usb_host_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  output logic             bitTick,
  output logic             tokenValid,
  output logic [6:0]       tokenAddr,
  output logic [3:0]       tokenEndp,
  output logic             tokenCrcOk,
  output logic             transactionEnd,
  output logic             ackStatus,
  output logic             startOfFrameSeen,
  output logic [15:0]      sofFrame,
  output logic             txSuccess,
  output logic             rxPidValid,
  output logic             rxPid
);
  initial begin
    {tokenValid, tokenAddr, tokenEndp, tokenCrcOk, ackStatus} = '0;
    {startOfFrameSeen, sofFrame, txSuccess, rxPidValid, rxPid} = '0;
    transactionEnd = 1'b1;
  end
  // bit clock tick every second core cycle, close to full speed rate
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bitTick <= 1'b0;
    end else begin
      bitTick <= ~bitTick;
    end
  end
  // token opens a transaction; fields scrambled once the pulse is gone
  task automatic token(input logic [6:0] a, input logic [3:0] e, input logic c);
    transactionEnd <= 1'b0;
    tokenValid     <= 1'b1;
    tokenAddr      <= a;
    tokenEndp      <= e;
    tokenCrcOk     <= c;
    @(posedge core_clk);
    tokenValid <= 1'b0;
    tokenAddr  <= ~a;
    tokenEndp  <= ~e;
    tokenCrcOk <= ~c;
  endtask
  task automatic sent();
    txSuccess <= 1'b1;
    @(posedge core_clk);
    txSuccess <= 1'b0;
  endtask
  task automatic got(input logic p);
    rxPidValid <= 1'b1;
    rxPid      <= p;
    @(posedge core_clk);
    rxPidValid <= 1'b0;
    rxPid      <= ~p;
  endtask
  task automatic finish();
    transactionEnd <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask
  // one sof every four cycles when called back to back
  task automatic sof(input logic [15:0] f, input logic a);
    transactionEnd   <= 1'b0;
    startOfFrameSeen <= 1'b1;
    ackStatus        <= a;
    sofFrame         <= f;
    @(posedge core_clk);
    transactionEnd <= 1'b1;
    @(posedge core_clk);
    startOfFrameSeen <= 1'b0;
    sofFrame         <= ~f;
    repeat (2) @(posedge core_clk);
  endtask
endmodule

// >>> dv/usb_frame_addr_test.sv
// self-checking bench for the endpoint, frame and address block
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin num_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module usb_frame_addr_test;
  import usb_frame_addr_pkg::*;
  localparam logic [16:0] EP1 = ADDR_ENDPOINT_CONTROL + 17'h4;
  localparam logic [16:0] EP2 = ADDR_ENDPOINT_CONTROL + 17'h8;
  localparam logic [16:0] EP3 = ADDR_ENDPOINT_CONTROL + 17'hC;
  logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, rxReady = 1, txQueued = 1;
  logic [16:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, bitTick, tokenValid, tokenCrcOk, transactionEnd, ackStatus;
  logic startOfFrameSeen, txSuccess, rxPidValid, rxPid, endpointMatch, alternateHit;
  logic acceptAll, rxToggleError, e;
  logic [6:0]  tokenAddr;
  logic [3:0]  tokenEndp, activeEndpoint;
  logic [15:0] sofFrame;
  logic [7:0]  activeControl, q, v;
  handshake_e  inHandshake, outHandshake;
  int num_errors = 0, n_compared = 0, errPulses = 0, cycles = 0;
  logic [16:0] regs [5] = '{ADDR_ENDPOINT_CONTROL, ADDR_EP_LAST, ADDR_FRAME_LO, ADDR_LOCAL_ADDR, ADDR_SECOND_ADR};

  usb_frame_addr uut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bitTick(bitTick),
    .tokenValid(tokenValid), .tokenAddr(tokenAddr), .tokenEndp(tokenEndp), .tokenCrcOk(tokenCrcOk),
    .transactionEnd(transactionEnd), .ackStatus(ackStatus), .startOfFrameSeen(startOfFrameSeen),
    .sofFrame(sofFrame), .txSuccess(txSuccess), .rxPidValid(rxPidValid), .rxPid(rxPid), .rxReady(rxReady),
    .txQueued(txQueued), .endpointMatch(endpointMatch), .alternateHit(alternateHit),
    .activeEndpoint(activeEndpoint), .activeControl(activeControl), .inHandshake(inHandshake),
    .outHandshake(outHandshake), .acceptAll(acceptAll), .rxToggleError(rxToggleError));
  usb_host_model host (.core_clk(core_clk), .rst(rst), .bitTick(bitTick), .tokenValid(tokenValid),
    .tokenAddr(tokenAddr), .tokenEndp(tokenEndp), .tokenCrcOk(tokenCrcOk), .transactionEnd(transactionEnd),
    .ackStatus(ackStatus), .startOfFrameSeen(startOfFrameSeen), .sofFrame(sofFrame), .txSuccess(txSuccess),
    .rxPidValid(rxPidValid), .rxPid(rxPid));

  always #25 core_clk = ~core_clk;
  // toggle error is a one-cycle pulse, so count it on every edge
  always @(posedge core_clk) begin
    if (rxToggleError === 1'b1) errPulses++;
  end
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////
  // one apb transfer; request held until pready seen at an edge
  task automatic apb(input logic w, input logic [16:0] a, input logic [7:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    // no local limit: only the bench timeout ends a wait for pready
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    q = prdata[7:0];
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [16:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [16:0] a, input logic [7:0] ex);
    apb(1'b0, a, 8'h00);
    `CHK($sformatf("reg %h", a), ex, q)
  endtask
  // token, then match is looked at once its register has updated
  task automatic tok(input logic [6:0] a, input logic [3:0] n, input logic c, input logic m);
    host.token(a, n, c);
    @(posedge core_clk);
    `CHK("endpointMatch", m, endpointMatch)
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    foreach (regs[i]) rdchk(regs[i], 8'h00);
    apb(1'b0, ADDR_ENGINE_CFG + 17'h4, 8'h00);
    `CHK("pslverr", 1'b1, e)
    wr(ADDR_FRAME_LO, 8'hFF);
    rdchk(ADDR_FRAME_LO, 8'h00);
    // address decode: local, second and promiscuous paths
    wr(ADDR_LOCAL_ADDR, 8'h15);
    rdchk(ADDR_LOCAL_ADDR, 8'h15);
    wr(ADDR_SECOND_ADR, 8'h2A);
    tok(7'h15, 4'h2, 1'b1, 1'b1);
    tok(7'h15, 4'h4, 1'b1, 1'b0);
    tok(7'h2A, 4'h9, 1'b1, 1'b0);
    tok(7'h15, 4'h3, 1'b0, 1'b0);
    wr(ADDR_SECOND_ADR, 8'hAA);
    tok(7'h2A, 4'h9, 1'b1, 1'b1);
    `CHK("alternateHit", 1'b1, alternateHit)
    tok(7'h2A, 4'hF, 1'b1, 1'b1);
    tok(7'h6A, 4'h1, 1'b1, 1'b0);
    `CHK("alternateHit", 1'b0, alternateHit)
    wr(ADDR_LOCAL_ADDR, 8'h95);
    tok(7'h33, 4'h7, 1'b0, 1'b1);
    `CHK("acceptAll", 1'b1, acceptAll)
    host.finish();
    wr(ADDR_LOCAL_ADDR, 8'h15);
    // every response code on both directions of endpoint 3
    for (int c = 0; c < 4; c++) begin
      v = {2'b00, c[1], c[1], c[0], c[0], 2'b00};
      wr(EP3, v);
      tok(7'h15, 4'h3, 1'b1, 1'b1);
      `CHK("inHandshake", handshake_e'(c[1:0]), inHandshake)
      `CHK("outHandshake", handshake_e'(c[1:0]), outHandshake)
      host.finish();
    end
    // ready and queue levels low: normal code answers nak, iso receive none
    wr(EP3, 8'h30);
    rxReady  <= 1'b0;
    txQueued <= 1'b0;
    @(posedge core_clk);
    `CHK("outHandshake", HS_NAK, outHandshake)
    `CHK("inHandshake", HS_NAK, inHandshake)
    wr(EP3, 8'h70);
    `CHK("outHandshake", HS_NONE, outHandshake)
    rxReady  <= 1'b1;
    txQueued <= 1'b1;
    // transmit parity on endpoint 2, ordinary then isochronous
    wr(EP2, 8'h30);
    host.token(7'h15, 4'h2, 1'b1);
    host.sent();
    host.finish();
    rdchk(EP2, 8'h32);
    wr(EP2, 8'h02);
    wr(EP2, 8'h80);
    wr(EP2, 8'hB0);
    host.token(7'h15, 4'h2, 1'b1);
    host.sent();
    host.finish();
    rdchk(EP2, 8'hB0);
    // receive parity and toggle mismatch, ordinary then isochronous
    wr(EP2, 8'h30);
    for (int k = 0; k < 4; k++) begin
      if (k == 2) wr(EP2, 8'h70);
      host.token(7'h15, 4'h2, 1'b1);
      host.got(k != 3);
      host.finish();
    end
    `CHK("errPulses", 1, errPulses)
    rdchk(EP2, 8'h70);
    // writes during a busy transaction wait for its end, last one wins
    wr(EP1, 8'h30);
    host.token(7'h15, 4'h1, 1'b1);
    wr(EP1, 8'h20);
    wr(EP1, 8'h10);
    `CHK("activeEndpoint", 4'h1, activeEndpoint)
    `CHK("activeControl", 8'h30, activeControl)
    host.finish();
    `CHK("activeControl", 8'h10, activeControl)
    // frame number: load, missing sof with wrap, bad sof, extension
    host.sof(16'h07FE, 1'b1);
    host.sof(16'h07FF, 1'b1);
    rdchk(ADDR_FRAME_LO, 8'hFF);
    rdchk(ADDR_FRAME_HI, 8'h07);
    repeat (6) @(posedge core_clk);
    rdchk(ADDR_FRAME_LO, 8'h00);
    rdchk(ADDR_FRAME_HI, 8'h00);
    host.sof(16'hABCD, 1'b1);
    host.sof(16'hABCD, 1'b1);
    host.sof(16'h0000, 1'b0);
    rdchk(ADDR_FRAME_LO, 8'hCE);
    rdchk(ADDR_FRAME_HI, 8'h03);
    wr(ADDR_ENGINE_CFG, 8'h01);
    host.sof(16'hABCD, 1'b1);
    host.sof(16'hABCD, 1'b1);
    rdchk(ADDR_FRAME_LO, 8'hCD);
    rdchk(ADDR_FRAME_HI, 8'hAB);
    end_of_test();
  end
endmodule
